// File: rtl/dah_pkg.sv
// package: register map, field codes and reset values for the dual alarm block
// What this block does
// RULE_01: two alarm channels with fully separate state, settings and contacts.
// RULE_02: each channel selects oxygen or temperature as its input value.
// RULE_03: each channel selects high, low, deviation or fault function.
// RULE_04: each channel has an enable; disabled channel never alarms; code clears a held alarm only at the next sample strobe.
// RULE_05: oxygen setpoint accepts 0 through 9999 in the selected unit.
// RULE_06: temperature setpoint accepts -5 C through 105 C.
// RULE_07: oxygen differential programmable from 0 up to 100 units.
// RULE_08: contact polarity resets to normally open.
// RULE_09: normally open contact is active exactly while alarm present.
// RULE_10: contact level is alarm state xor polarity, inverted for normally closed.
// RULE_11: polarity still applies when contacts show range number.
// RULE_12: range mode off by default; alarm drives indicator and its contact.
// RULE_13: range mode on: alarms drive indicator only, contacts carry range code.
// RULE_14: per-channel unit selects ppm or ppb for oxygen.
// RULE_15: per-channel unit selects Celsius or Fahrenheit for temperature.
// RULE_16: high alarm sets above setpoint, clears below setpoint minus differential.
// RULE_17: low alarm sets below setpoint, clears above setpoint plus differential.
// RULE_18: range code A,B: 1=00, 2=01, 3=10, 4=11, 5=00.
// RULE_19: deviation alarm asserts when value departs setpoint by more than deviation.
// RULE_20: fault alarm asserts on off-scale or unacknowledged error; thresholds ignored.
// RULE_21: alarm states update once per sample strobe and reset inactive.
// RULE_22: comparisons use signed fixed-point values in the selected unit.
package dah_pkg;
    localparam int DAH_VAL_W = 16;
    localparam logic [3:0] DAH_OFS_CTRL = 4'h0;
    localparam logic [3:0] DAH_OFS_SET_A = 4'h1;
    localparam logic [3:0] DAH_OFS_DIF_A = 4'h2;
    localparam logic [3:0] DAH_OFS_DEV_A = 4'h3;
    localparam logic [3:0] DAH_OFS_SET_B = 4'h4;
    localparam logic [3:0] DAH_OFS_DIF_B = 4'h5;
    localparam logic [3:0] DAH_OFS_DEV_B = 4'h6;
    localparam logic [3:0] DAH_OFS_STAT = 4'h7;
    localparam logic [31:0] DAH_BAD_DATA = 32'hDEAD_BEEF;
    // channel config byte: [0] enable [1] source [3:2] type [4] unit [5] normally closed
    localparam int DAH_CF_EN = 0;
    localparam int DAH_CF_SRC = 1;
    localparam int DAH_CF_TYP = 2;
    localparam int DAH_CF_UNIT = 4;
    localparam int DAH_CF_NC = 5;
    localparam int DAH_CTRL_RANGE_BIT = 16;
    localparam logic [7:0] DAH_CFG_RST = 8'h00;
    localparam logic signed [15:0] DAH_OXY_MIN = 16'sh0000;
    localparam logic signed [15:0] DAH_OXY_MAX = 16'sh270F;
    localparam logic signed [15:0] DAH_TMP_MIN_C = -16'sh0005;
    localparam logic signed [15:0] DAH_TMP_MAX_C = 16'sh0069;
    localparam logic signed [15:0] DAH_TMP_MIN_F = 16'sh0017;
    localparam logic signed [15:0] DAH_TMP_MAX_F = 16'sh00DD;
    localparam logic signed [15:0] DAH_DIF_MAX_OXY = 16'sh0064;
    localparam logic [15:0] DAH_SET_RST = 16'h0000;
    typedef enum logic [1:0] {DAH_HIGH = 2'h0, DAH_LOW = 2'h1, DAH_DEV = 2'h2, DAH_FAULT = 2'h3} dah_type_t;
    typedef enum logic [1:0] {DAH_BUS_IDLE = 2'h1, DAH_BUS_DONE = 2'h2} dah_bus_t;
endpackage : dah_pkg

// File: rtl/dah_chan_if.sv
// interface: settings and result of one alarm channel
`timescale 1ns/1ps
interface dah_chan_if;
    import dah_pkg::*;
    logic en;
    logic src;
    dah_type_t typ;
    logic unit;
    logic signed [DAH_VAL_W-1:0] setp;
    logic signed [DAH_VAL_W-1:0] dif;
    logic signed [DAH_VAL_W-1:0] dev;
    logic alarm;
    modport cfg (output en, output src, output typ, output unit, output setp, output dif, output dev, input alarm);
    modport eval (input en, input src, input typ, input unit, input setp, input dif, input dev, output alarm);
endinterface : dah_chan_if

// File: rtl/dah_alarm_eval.sv
// one alarm channel evaluator with hysteresis state
`timescale 1ns/1ps
module dah_alarm_eval
    import dah_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic sample_stb,
    input wire logic signed [DAH_VAL_W-1:0] oxy_val,
    input wire logic signed [DAH_VAL_W-1:0] tmp_val,
    input wire logic fault_in,
    dah_chan_if.eval ch
);
    typedef struct packed {
        logic alarm;
    } dah_ev_st_t;
    dah_ev_st_t st_r;
    dah_ev_st_t st_nxt;
    logic signed [DAH_VAL_W:0] val;
    logic signed [DAH_VAL_W:0] sp;
    logic signed [DAH_VAL_W:0] df;
    logic signed [DAH_VAL_W:0] dv;
    always_comb begin
        st_nxt = st_r;
        val = ch.src ? {tmp_val[DAH_VAL_W-1], tmp_val} : {oxy_val[DAH_VAL_W-1], oxy_val}; // RULE_02 RULE_22
        sp = {ch.setp[DAH_VAL_W-1], ch.setp};
        df = {ch.dif[DAH_VAL_W-1], ch.dif};
        dv = {ch.dev[DAH_VAL_W-1], ch.dev};
        if (sample_stb) begin // RULE_21
            if (!ch.en) begin
                st_nxt.alarm = 1'b0; // RULE_04
            end else begin
                unique case (ch.typ) // RULE_03
                    DAH_HIGH: begin
                        if (val > sp) begin
                            st_nxt.alarm = 1'b1; // RULE_16
                        end else if (val < sp - df) begin
                            st_nxt.alarm = 1'b0; // RULE_16
                        end
                    end
                    DAH_LOW: begin
                        if (val < sp) begin
                            st_nxt.alarm = 1'b1; // RULE_17
                        end else if (val > sp + df) begin
                            st_nxt.alarm = 1'b0; // RULE_17
                        end
                    end
                    DAH_DEV: begin
                        st_nxt.alarm = (val > sp + dv) || (val < sp - dv); // RULE_19
                    end
                    DAH_FAULT: begin
                        st_nxt.alarm = fault_in; // RULE_20
                    end
                endcase
            end
        end
    end
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            st_r <= '0; // RULE_21
        end else begin
            st_r <= st_nxt;
        end
    end
    assign ch.alarm = st_r.alarm;
endmodule : dah_alarm_eval

// File: rtl/dah_top.sv
// top: avalon register file, two alarm channels, contact and indicator outputs
//
// Local design decisions: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/1ps
module dah_top
    import dah_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic sample_stb,
    input wire logic signed [DAH_VAL_W-1:0] oxy_val,
    input wire logic signed [DAH_VAL_W-1:0] tmp_val,
    input wire logic oxy_fault,
    input wire logic tmp_fault,
    input wire logic [2:0] range_num,
    output logic [1:0] alarm_led,
    output logic [1:0] contact_out
);
    typedef struct packed {
        logic [1:0][7:0] cfg;
        logic [1:0][DAH_VAL_W-1:0] setp;
        logic [1:0][DAH_VAL_W-1:0] dif;
        logic [1:0][DAH_VAL_W-1:0] dev;
        logic contact_range_mode;
        dah_bus_t bus;
        logic [31:0] rdata;
        logic [1:0] led;
        logic [1:0] contact;
    } dah_st_t;
    dah_st_t st_r;
    dah_st_t st_nxt;
    logic [1:0] alarm;
    logic [1:0] range_code;
    dah_chan_if ch_a();
    dah_chan_if ch_b();

    function automatic logic signed [DAH_VAL_W-1:0] clamp_set(
        input logic [DAH_VAL_W-1:0] v,
        input logic src,
        input logic unit
    );
        logic signed [DAH_VAL_W-1:0] lo;
        logic signed [DAH_VAL_W-1:0] hi;
        logic signed [DAH_VAL_W-1:0] s;
        s = $signed(v);
        lo = src ? (unit ? DAH_TMP_MIN_F : DAH_TMP_MIN_C) : DAH_OXY_MIN; // RULE_05 RULE_06 RULE_15
        hi = src ? (unit ? DAH_TMP_MAX_F : DAH_TMP_MAX_C) : DAH_OXY_MAX; // RULE_05 RULE_06 RULE_15
        if (s < lo) begin
            return lo;
        end
        if (s > hi) begin
            return hi;
        end
        return s;
    endfunction : clamp_set

    function automatic logic signed [DAH_VAL_W-1:0] clamp_dif(
        input logic [DAH_VAL_W-1:0] v,
        input logic src
    );
        logic signed [DAH_VAL_W-1:0] s;
        s = $signed(v);
        if (s < 16'sh0000) begin
            return 16'sh0000;
        end
        if (!src && s > DAH_DIF_MAX_OXY) begin
            return DAH_DIF_MAX_OXY; // RULE_07
        end
        return s;
    endfunction : clamp_dif

    // channel settings onto the interfaces
    assign ch_a.en = st_r.cfg[0][DAH_CF_EN];
    assign ch_a.src = st_r.cfg[0][DAH_CF_SRC];
    assign ch_a.typ = dah_type_t'(st_r.cfg[0][DAH_CF_TYP +: 2]);
    assign ch_a.unit = st_r.cfg[0][DAH_CF_UNIT]; // RULE_14
    assign ch_a.setp = st_r.setp[0];
    assign ch_a.dif = st_r.dif[0];
    assign ch_a.dev = st_r.dev[0];
    assign ch_b.en = st_r.cfg[1][DAH_CF_EN];
    assign ch_b.src = st_r.cfg[1][DAH_CF_SRC];
    assign ch_b.typ = dah_type_t'(st_r.cfg[1][DAH_CF_TYP +: 2]);
    assign ch_b.unit = st_r.cfg[1][DAH_CF_UNIT]; // RULE_14
    assign ch_b.setp = st_r.setp[1];
    assign ch_b.dif = st_r.dif[1];
    assign ch_b.dev = st_r.dev[1];

    // two separate evaluators, no shared state
    dah_alarm_eval u_eval_a ( // RULE_01
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .sample_stb(sample_stb),
        .oxy_val(oxy_val),
        .tmp_val(tmp_val),
        .fault_in(ch_a.src ? tmp_fault : oxy_fault),
        .ch(ch_a)
    );
    dah_alarm_eval u_eval_b ( // RULE_01
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .sample_stb(sample_stb),
        .oxy_val(oxy_val),
        .tmp_val(tmp_val),
        .fault_in(ch_b.src ? tmp_fault : oxy_fault),
        .ch(ch_b)
    );
    assign alarm = {ch_b.alarm, ch_a.alarm};

    // range number to A,B contact pattern
    always_comb begin
        unique case (range_num) // RULE_18
            3'h2: range_code = 2'h1;
            3'h3: range_code = 2'h2;
            3'h4: range_code = 2'h3;
            default: range_code = 2'h0;
        endcase
    end

    always_comb begin
        st_nxt = st_r;
        st_nxt.led = alarm; // RULE_12 RULE_13
        for (int i = 0; i < 2; i++) begin
            if (st_r.contact_range_mode) begin
                // index 0 is contact A which carries the high code bit
                st_nxt.contact[i] = range_code[1-i] ^ st_r.cfg[i][DAH_CF_NC]; // RULE_13 RULE_11
            end else begin
                st_nxt.contact[i] = alarm[i] ^ st_r.cfg[i][DAH_CF_NC]; // RULE_12 RULE_09 RULE_10
            end
        end
        unique case (st_r.bus)
            DAH_BUS_IDLE: begin
                if (avs_write) begin
                    st_nxt.bus = DAH_BUS_DONE;
                    unique case (avs_address)
                        DAH_OFS_CTRL: begin
                            for (int i = 0; i < 2; i++) begin
                                if (avs_byteenable[i]) begin
                                    st_nxt.cfg[i] = avs_writedata[i*8 +: 8];
                                end
                            end
                            if (avs_byteenable[2]) begin
                                st_nxt.contact_range_mode = avs_writedata[DAH_CTRL_RANGE_BIT];
                            end
                        end
                        DAH_OFS_SET_A: st_nxt.setp[0] = clamp_set(avs_writedata[15:0], st_r.cfg[0][DAH_CF_SRC],
                            st_r.cfg[0][DAH_CF_UNIT]);
                        DAH_OFS_DIF_A: st_nxt.dif[0] = clamp_dif(avs_writedata[15:0], st_r.cfg[0][DAH_CF_SRC]);
                        DAH_OFS_DEV_A: st_nxt.dev[0] = clamp_dif(avs_writedata[15:0], 1'b1);
                        DAH_OFS_SET_B: st_nxt.setp[1] = clamp_set(avs_writedata[15:0], st_r.cfg[1][DAH_CF_SRC],
                            st_r.cfg[1][DAH_CF_UNIT]);
                        DAH_OFS_DIF_B: st_nxt.dif[1] = clamp_dif(avs_writedata[15:0], st_r.cfg[1][DAH_CF_SRC]);
                        DAH_OFS_DEV_B: st_nxt.dev[1] = clamp_dif(avs_writedata[15:0], 1'b1);
                        default: begin
                        end
                    endcase
                end else if (avs_read) begin
                    st_nxt.bus = DAH_BUS_DONE;
                    unique case (avs_address)
                        DAH_OFS_CTRL: st_nxt.rdata = {15'h0000, st_r.contact_range_mode, st_r.cfg[1], st_r.cfg[0]};
                        DAH_OFS_SET_A: st_nxt.rdata = {16'h0000, st_r.setp[0]};
                        DAH_OFS_DIF_A: st_nxt.rdata = {16'h0000, st_r.dif[0]};
                        DAH_OFS_DEV_A: st_nxt.rdata = {16'h0000, st_r.dev[0]};
                        DAH_OFS_SET_B: st_nxt.rdata = {16'h0000, st_r.setp[1]};
                        DAH_OFS_DIF_B: st_nxt.rdata = {16'h0000, st_r.dif[1]};
                        DAH_OFS_DEV_B: st_nxt.rdata = {16'h0000, st_r.dev[1]};
                        DAH_OFS_STAT: st_nxt.rdata = {26'h0000000, st_r.contact, st_r.led, alarm};
                        default: st_nxt.rdata = DAH_BAD_DATA;
                    endcase
                end
            end
            DAH_BUS_DONE: begin
                st_nxt.bus = DAH_BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            st_r.cfg <= {DAH_CFG_RST, DAH_CFG_RST}; // RULE_08
            st_r.setp <= {DAH_SET_RST, DAH_SET_RST};
            st_r.dif <= {DAH_SET_RST, DAH_SET_RST};
            st_r.dev <= {DAH_SET_RST, DAH_SET_RST};
            st_r.contact_range_mode <= 1'b0; // RULE_12
            st_r.bus <= DAH_BUS_IDLE;
            st_r.rdata <= 32'h00000000;
            st_r.led <= 2'h0;
            st_r.contact <= 2'h0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign avs_readdata = st_r.rdata;
    assign avs_waitrequest = st_r.bus[0];
    assign alarm_led = st_r.led;
    assign contact_out = st_r.contact;
endmodule : dah_top

// File: verification/dah_recorder.sv
// partner: remote recorder sampling the two contact lines
`timescale 1ns/1ps
module dah_recorder (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [1:0] contact_out,
    output logic [1:0] seen_r
);
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            seen_r <= 2'h0;
        end else begin
            seen_r <= contact_out;
        end
    end
endmodule : dah_recorder

// File: verification/dah_top_sva.sv
// checker: port-level properties of the dual alarm block
`timescale 1ns/1ps
module dah_top_sva
    import dah_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic sample_stb,
    input wire logic [2:0] range_num,
    input wire logic [1:0] alarm_led,
    input wire logic [1:0] contact_out
);
    logic [16:0] ctrl_r;
    logic [2:0] rng_r;
    logic [2:0] q_r;
    logic wr0;
    logic [1:0] code;
    logic [1:0] nc;
    assign wr0 = avs_write && !avs_waitrequest && avs_address == DAH_OFS_CTRL;
    assign nc = {ctrl_r[13], ctrl_r[5]};
    always_comb begin
        case (range_num)
            3'h2: code = 2'b10;
            3'h3: code = 2'b01;
            3'h4: code = 2'b11;
            default: code = 2'b00;
        endcase
    end
    // shadow of control word and quiet-cycle count
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            ctrl_r <= 17'h0;
            rng_r <= 3'h0;
            q_r <= 3'h0;
        end else begin
            rng_r <= range_num;
            if (wr0 && avs_byteenable[0]) begin
                ctrl_r[7:0] <= avs_writedata[7:0];
            end
            if (wr0 && avs_byteenable[1]) begin
                ctrl_r[15:8] <= avs_writedata[15:8];
            end
            if (wr0 && avs_byteenable[2]) begin
                ctrl_r[16] <= avs_writedata[16];
            end
            if (wr0 || range_num != rng_r) begin
                q_r <= 3'h0;
            end else if (q_r != 3'h7) begin
                q_r <= q_r + 3'h1;
            end
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    sequence s_taken;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    sequence s_settled;
        q_r >= 3'h2 && $past(sample_stb, 2);
    endsequence
    a_wait_one: assert property (s_taken |=> !avs_waitrequest) else $error("no answer after one wait state");
    a_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest) else $error("answer longer than one cycle");
    a_bad_read: assert property (avs_read && !avs_waitrequest && avs_address > 4'h7
        |-> avs_readdata == DAH_BAD_DATA) else $error("unmapped read data wrong");
    a_stat_view: assert property (avs_read && !avs_waitrequest && avs_address == DAH_OFS_STAT
        && $stable(alarm_led) && $stable(contact_out) |-> avs_readdata[5:2] == {contact_out, alarm_led})
        else $error("status word mismatch");
    a_led_sample: assert property ($past(rst_n) && !$stable(alarm_led) |-> $past(sample_stb, 2))
        else $error("indicator changed without sample");
    a_reset_idle: assert property ($rose(rst_n) |-> avs_waitrequest && alarm_led == 2'b00
        && contact_out == 2'b00) else $error("outputs not idle after reset");
    a_contact_alarm: assert property (s_settled and !ctrl_r[16] |-> contact_out == (alarm_led ^ nc))
        else $error("contact not alarm xor polarity");
    a_contact_range: assert property (s_settled and ctrl_r[16] |-> contact_out == (code ^ nc))
        else $error("contact not range code");
    a_chan_off: assert property (s_settled and !ctrl_r[0] |-> !alarm_led[0])
        else $error("disabled channel alarmed");
endmodule : dah_top_sva
bind dah_top dah_top_sva i_sva (.clk_sys, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .sample_stb, .range_num, .alarm_led, .contact_out);

// File: verification/testbench.sv
// testbench: scenario tasks for the dual alarm block
`timescale 1ns/1ps
module testbench;
    import dah_pkg::*;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'hF;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic sample_stb = 1'b0;
    logic signed [15:0] oxy_val = 16'sh0;
    logic signed [15:0] tmp_val = 16'sh0;
    logic oxy_fault = 1'b0;
    logic tmp_fault = 1'b0;
    logic [2:0] range_num = 3'h1;
    logic [1:0] alarm_led;
    logic [1:0] contact_out;
    logic [1:0] seen;
    logic [31:0] rd;
    logic [1:0] code [1:5] = '{2'b00, 2'b10, 2'b01, 2'b11, 2'b00};
    int err_total = 0;
    int cmp_count = 0;
    always #10 clk_sys = ~clk_sys;
    dah_top i_dut (.clk_sys, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
        .avs_readdata, .avs_waitrequest, .sample_stb, .oxy_val, .tmp_val, .oxy_fault, .tmp_fault,
        .range_num, .alarm_led, .contact_out);
    dah_recorder i_rec (.clk_sys, .rst_n, .contact_out, .seen_r(seen));
    task automatic end_sim();
        if (err_total == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : end_sim
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask : bus
    task automatic wrchk(input logic [3:0] a, input logic [31:0] d, input logic [31:0] exp);
        bus(1'b1, a, d);
        bus(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask : wrchk
    task automatic smp(input logic signed [15:0] o, input logic signed [15:0] t);
        @(posedge clk_sys);
        oxy_val <= o;
        tmp_val <= t;
        sample_stb <= 1'b1;
        @(posedge clk_sys);
        sample_stb <= 1'b0;
        repeat (3) @(posedge clk_sys);
    endtask : smp
    task automatic run(input int ch, input logic src, input logic signed [15:0] v [4], input logic [3:0] e);
        for (int i = 0; i < 4; i++) begin
            smp(src ? 16'sh0 : v[i], src ? v[i] : 16'sh0);
            chk(32'({alarm_led[ch], seen[ch], alarm_led[1-ch]}), 32'({e[i], e[i], 1'b0}));
        end
    endtask : run
    task automatic t_reset();
        bus(1'b0, DAH_OFS_CTRL, 32'h0);
        chk(rd, 32'h0);
        chk(32'(seen), 32'h0);
    endtask : t_reset
    task automatic t_thresholds();
        bus(1'b1, DAH_OFS_CTRL, 32'h01);
        bus(1'b1, DAH_OFS_SET_A, 32'h64);
        bus(1'b1, DAH_OFS_DIF_A, 32'h0A);
        run(0, 1'b0, '{16'sd100, 16'sd101, 16'sd91, 16'sd89}, 4'b0110);
        bus(1'b1, DAH_OFS_CTRL, 32'h0700);
        bus(1'b1, DAH_OFS_SET_B, 32'hFFFD);
        bus(1'b1, DAH_OFS_DIF_B, 32'h02);
        run(1, 1'b1, '{-16'sd3, -16'sd4, -16'sd1, 16'sd0}, 4'b0110);
        bus(1'b1, DAH_OFS_CTRL, 32'h09);
        bus(1'b1, DAH_OFS_SET_A, 32'h96);
        bus(1'b1, DAH_OFS_DEV_A, 32'h32);
        run(0, 1'b0, '{16'sd200, 16'sd201, 16'sd100, 16'sd99}, 4'b1010);
    endtask : t_thresholds
    task automatic t_fault();
        bus(1'b1, DAH_OFS_CTRL, 32'h0D);
        oxy_fault <= 1'b1;
        smp(16'sh0, 16'sh0);
        chk(32'(alarm_led), 32'h1);
        bus(1'b1, DAH_OFS_CTRL, 32'h0C);
        smp(16'sh0, 16'sh0);
        chk(32'(alarm_led), 32'h0);
        bus(1'b1, DAH_OFS_CTRL, 32'h0D);
        oxy_fault <= 1'b0;
        tmp_fault <= 1'b1;
        smp(16'sh0, 16'sh0);
        chk(32'(alarm_led), 32'h0);
        bus(1'b1, DAH_OFS_CTRL, 32'h0F);
        smp(16'sh0, 16'sh0);
        chk(32'(alarm_led), 32'h1);
        tmp_fault <= 1'b0;
    endtask : t_fault
    task automatic t_limits();
        bus(1'b1, DAH_OFS_CTRL, 32'h01);
        wrchk(DAH_OFS_SET_A, 32'h2710, 32'h270F);
        wrchk(DAH_OFS_DIF_A, 32'hC8, 32'h64);
        wrchk(DAH_OFS_CTRL, 32'h03, 32'h03);
        wrchk(DAH_OFS_SET_A, 32'hFFF6, 32'hFFFB);
        wrchk(DAH_OFS_CTRL, 32'h13, 32'h13);
        wrchk(DAH_OFS_SET_A, 32'h0, 32'h17);
        wrchk(DAH_OFS_CTRL, 32'h11, 32'h11);
        avs_byteenable <= 4'h1;
        wrchk(DAH_OFS_CTRL, 32'h0001FF03, 32'h03);
        avs_byteenable <= 4'hF;
        wrchk(4'h9, 32'h5, DAH_BAD_DATA);
    endtask : t_limits
    task automatic t_range();
        bus(1'b1, DAH_OFS_CTRL, 32'h10021);
        bus(1'b1, DAH_OFS_SET_A, 32'h64);
        for (int r = 1; r <= 5; r++) begin
            range_num <= 3'(r);
            smp(16'sd200, 16'sh0);
            chk(32'(alarm_led), 32'h1);
            chk(32'(seen), 32'(code[r] ^ 2'b01));
        end
        bus(1'b0, DAH_OFS_STAT, 32'h0);
        chk(rd, 32'h15);
        bus(1'b1, DAH_OFS_CTRL, 32'h20);
        smp(16'sd200, 16'sh0);
        chk(32'(seen), 32'h1);
    endtask : t_range
    initial begin
        repeat (20000) @(posedge clk_sys);
        err_total++;
        end_sim();
    end
    initial begin
        repeat (20) @(posedge clk_sys);
        rst_n <= 1'b1;
        t_reset();
        t_thresholds();
        t_fault();
        t_limits();
        t_range();
        end_sim();
    end
endmodule : testbench
